// File: rtl/flash_program_erase_control.sv
`timescale 1ns/1ps

module flash_program_erase_control
  import flash_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register port
  input  wire reg_req_t    req,
  output logic [7:0]       rdata,
  // charge pump and array supply
  output logic             pump_on,
  output logic             array_hv,
  // oscillator tune byte from the array
  output logic [7:0]       clock_tune_value
);

  // protect range start address built from the protect field
  function automatic logic [15:0] prot_start(input logic [7:0] field);
    prot_start = {PROT_TOP_BITS, field, 6'h00};
  endfunction

  // true when an address falls in the protected range
  function automatic logic is_protected(input logic [15:0] a, input logic [7:0] field);
    is_protected = (field != NO_PROTECT) && (a >= prot_start(field));
  endfunction

  // true when an address hits the modelled array
  function automatic logic in_array(input logic [15:0] a);
    in_array = (a[15:8] == ARRAY_BASE[15:8]);
  endfunction

  // array contents, erased to all ones except the tune byte
  logic [7:0] mem [ARRAY_SIZE];
  logic [7:0] next_mem [ARRAY_SIZE];

  // control register and sequence state
  array_operation_control_t ctrl;
  array_operation_control_t next_ctrl;
  seq_state_t               seq;
  seq_state_t               next_seq;
  logic [15:0]              latch_addr;
  logic [15:0]              next_latch_addr;
  logic [7:0]               next_rdata;
  logic                     next_pump_on;

  // decoded bus events
  logic       ctrl_wr;
  logic       array_wr;
  logic       prot_rd;
  logic [7:0] prot_field;
  logic       sel_any;
  logic       hv_request;
  logic       hv_allowed;
  logic       mass_ok;
  logic       new_pgm;
  logic       new_erase;

  // bus decode
  assign ctrl_wr    = req.wr && (req.addr == CTRL_ADDR);
  assign array_wr   = req.wr && in_array(req.addr);
  assign prot_rd    = req.rd && (req.addr == PROTECT_ADDR);
  assign prot_field = mem[PROTECT_IDX];
  assign sel_any    = ctrl.write_cycle_select || ctrl.block_clear_select;
  assign hv_request = ctrl_wr && req.wdata[CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT] && !ctrl.high_voltage_enable_bit;
  assign new_pgm    = req.wdata[CTRL_PGM_BIT];
  assign new_erase  = req.wdata[CTRL_ERASE_BIT];

  // mass erase only with no block protected
  assign mass_ok = (prot_field == NO_PROTECT);

  // gate for turning the high voltage on
  always_comb begin
    hv_allowed = 1'b0;
    if (seq == SEQ_ARMED && sel_any) begin
      if (ctrl.block_clear_select && ctrl.mass_select) begin
        hv_allowed = mass_ok;
      end else begin
        hv_allowed = !is_protected(latch_addr, prot_field);
      end
    end
  end

  // next control register value
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl.mass_select = req.wdata[CTRL_MASS_BIT];
      if (new_pgm && new_erase) begin
        // both selects asked at once: keep the present selects
        next_ctrl.write_cycle_select = ctrl.write_cycle_select;
        next_ctrl.block_clear_select = ctrl.block_clear_select;
      end else begin
        next_ctrl.write_cycle_select = new_pgm;
        next_ctrl.block_clear_select = new_erase;
      end
      if (!req.wdata[CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT]) begin
        next_ctrl.high_voltage_enable_bit = 1'b0;
      end else if (hv_request) begin
        next_ctrl.high_voltage_enable_bit = hv_allowed;
      end
    end
    next_ctrl.unused = 4'h0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // sequence tracker: select, protect read, array write, enable
  always_comb begin
    next_seq        = seq;
    next_latch_addr = latch_addr;
    case (seq)
      SEQ_IDLE: begin
        if (next_ctrl.write_cycle_select || next_ctrl.block_clear_select) begin
          next_seq = SEQ_SELECTED;
        end
      end
      SEQ_SELECTED: begin
        if (!sel_any) begin
          next_seq = SEQ_IDLE;
        end else if (prot_rd) begin
          next_seq = SEQ_PROT_READ;
        end
      end
      SEQ_PROT_READ: begin
        if (!sel_any) begin
          next_seq = SEQ_IDLE;
        end else if (array_wr) begin
          next_seq        = SEQ_ARMED;
          next_latch_addr = req.addr;
        end
      end
      SEQ_ARMED: begin
        if (next_ctrl.high_voltage_enable_bit) begin
          next_seq = SEQ_HIGH_VOLTAGE;
        end else if (!(next_ctrl.write_cycle_select || next_ctrl.block_clear_select)) begin
          next_seq = SEQ_IDLE;
        end
      end
      SEQ_HIGH_VOLTAGE: begin
        if (!next_ctrl.high_voltage_enable_bit) begin
          next_seq = SEQ_IDLE;
        end
      end
      default: begin
        next_seq = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seq        <= SEQ_IDLE;
      latch_addr <= 16'h0000;
    end else begin
      seq        <= next_seq;
      latch_addr <= next_latch_addr;
    end
  end

  // array update: erase on enable, program bytes within the latched row
  always_comb begin
    for (int i = 0; i < ARRAY_SIZE; i++) begin
      next_mem[i] = mem[i];
    end
    if (seq == SEQ_ARMED && next_seq == SEQ_HIGH_VOLTAGE && ctrl.block_clear_select) begin
      for (int i = 0; i < ARRAY_SIZE; i++) begin
        if (ctrl.mass_select) begin
          next_mem[i] = ERASED_BYTE;
        end else if (i[7:PAGE_LSB] == latch_addr[7:PAGE_LSB]) begin
          next_mem[i] = ERASED_BYTE;
        end
      end
    end
    if (seq == SEQ_HIGH_VOLTAGE && ctrl.write_cycle_select && array_wr
        && req.addr[15:ROW_LSB] == latch_addr[15:ROW_LSB]) begin
      // programming only drives ones to zero
      next_mem[req.addr[7:0]] = mem[req.addr[7:0]] & req.wdata;
    end
  end

  // array storage comes up erased with the tune byte in place
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < ARRAY_SIZE; i++) begin
        mem[i] <= (i == int'(TUNE_IDX)) ? TUNE_DEFAULT : ERASED_BYTE;
      end
    end else begin
      for (int i = 0; i < ARRAY_SIZE; i++) begin
        mem[i] <= next_mem[i];
      end
    end
  end

  // read data, valid the cycle after the strobe
  always_comb begin
    next_rdata = UNMAPPED_READ;
    if (req.rd) begin
      if (req.addr == CTRL_ADDR) begin
        next_rdata = ctrl;
      end else if (in_array(req.addr)) begin
        next_rdata = mem[req.addr[7:0]];
      end
    end
  end

  // high voltage and pump follow the enable bit
  always_comb begin
    next_pump_on = next_ctrl.high_voltage_enable_bit;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata            <= 8'h00;
      pump_on          <= 1'b0;
      array_hv         <= 1'b0;
      clock_tune_value <= TUNE_DEFAULT;
    end else begin
      rdata            <= next_rdata;
      pump_on          <= next_pump_on;
      array_hv         <= next_pump_on;
      clock_tune_value <= next_mem[TUNE_IDX];
    end
  end

endmodule

// File: shared/flash_ctl_pkg.sv
package flash_ctl_pkg;

  // bus widths and array geometry
  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 8;
  localparam int ARRAY_SIZE = 256;
  localparam int ARRAY_AW   = 8;
  localparam int PAGE_BYTES = 64;
  localparam int ROW_BYTES  = 32;
  localparam int PAGE_LSB   = 6;
  localparam int ROW_LSB    = 5;

  // register and array addresses
  localparam logic [15:0] CTRL_ADDR    = 16'hFE08;
  localparam logic [15:0] ARRAY_BASE   = 16'hFF00;
  localparam logic [15:0] PROTECT_ADDR = 16'hFFBE;
  localparam logic [15:0] TUNE_ADDR    = 16'hFFC0;
  localparam logic [7:0]  PROTECT_IDX  = 8'hBE;
  localparam logic [7:0]  TUNE_IDX     = 8'hC0;

  // control register field positions
  localparam int CTRL_PGM_BIT   = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam int CTRL_MASS_BIT  = 2;
  localparam int CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT  = 3;

  // values
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  localparam logic [7:0] NO_PROTECT    = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [1:0] PROT_TOP_BITS = 2'h3;
  localparam logic [7:0] TUNE_DEFAULT  = 8'h80; // arbitrary neutral value

  // control register image
  typedef struct packed {
    logic [3:0] unused;
    logic       high_voltage_enable_bit;
    logic       mass_select;
    logic       block_clear_select;
    logic       write_cycle_select;
  } array_operation_control_t;

  // register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // operation sequence tracking
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_SELECTED,
    SEQ_PROT_READ,
    SEQ_ARMED,
    SEQ_HIGH_VOLTAGE
  } seq_state_t;

endpackage

// File: sim/flash_ctl_props.sv
`timescale 1ns/1ps
module flash_ctl_props
  import flash_ctl_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // watched ports
  input wire reg_req_t   req,
  input wire logic [7:0] rdata,
  input wire logic       pump_on,
  input wire logic       array_hv,
  input wire logic [7:0] clock_tune_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // decoded control accesses
  wire       ctl_wr = req.wr && (req.addr == CTRL_ADDR);
  wire       ctl_rd = req.rd && (req.addr == CTRL_ADDR);
  wire       hv_wr  = ctl_wr && req.wdata[CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT];
  wire [2:0] wsel   = req.wdata[2:0];
  // single-cycle and multi-step access patterns
  sequence both_sel_wr; ctl_wr && (wsel[1:0] == 2'h3); endsequence
  sequence one_sel_wr; ctl_wr && (wsel[1:0] != 2'h3); endsequence
  sequence clear_then_hv; ctl_wr && (req.wdata == 8'h00) ##1 !req.wr ##1
    hv_wr && (wsel[1:0] == 2'h0); endsequence
  hv_follows_pump_a: assert property (array_hv == pump_on)
    else $error("array supply differs from pump state");
  hv_needs_write_a: assert property ($rose(pump_on) |-> $past(hv_wr))
    else $error("pump started without an enabling write");
  hv_no_select_a: assert property (clear_then_hv |=> !pump_on)
    else $error("pump started with no operation selected");
  hv_off_a: assert property (ctl_wr && !req.wdata[CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT] |=> !pump_on)
    else $error("pump still on after enable cleared");
  hv_holds_a: assert property (pump_on && !ctl_wr |=> pump_on)
    else $error("pump dropped without a control write");
  // the bench leaves one idle cycle between a write and the following read
  sel_interlock_a: assert property (both_sel_wr ##2 ctl_rd |=> rdata[1:0] != 2'h3)
    else $error("both selects read back as one");
  sel_readback_a: assert property (one_sel_wr ##2 ctl_rd |=> rdata[2:0] == $past(wsel, 3))
    else $error("select bits do not read back as written");
  tune_needs_hv_a: assert property ($changed(clock_tune_value) |-> pump_on)
    else $error("array byte changed without high voltage");
endmodule

// File: sim/flash_program_erase_control_tb_top.sv
`timescale 1ns/1ps
module flash_program_erase_control_tb_top;
  import flash_ctl_pkg::*;
  logic       clk        = 1'b0;
  logic       srst       = 1'b1;
  reg_req_t   req        = '0;
  logic [7:0] rdata;
  logic       pump_on;
  logic       array_hv;
  logic [7:0] clock_tune_value;
  logic [7:0] d          = 8'hFF; // expected protect byte
  int         n_mismatch = 0;
  int         cmp_count  = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  flash_program_erase_control uut (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
    .pump_on(pump_on), .array_hv(array_hv), .clock_tune_value(clock_tune_value));

  // compare and count
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle bus write
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= v;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask
  // read and compare the data of the following cycle
  task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(what, rdata, exp);
  endtask
  task automatic pchk(input logic e);
    chk("pump_on", {7'h00, pump_on}, {7'h00, e});
  endtask
  // select, read protect byte, latch address, enable voltage
  task automatic arm(input logic [7:0] sel, input logic [15:0] a);
    wr(CTRL_ADDR, sel);
    rchk("protect", PROTECT_ADDR, d);
    wr(a, 8'hFF);
    wr(CTRL_ADDR, sel | 8'h08);
  endtask

  task automatic t_reset;
    rchk("ctrl", CTRL_ADDR, 8'h00);
    rchk("array", 16'hFF41, ERASED_BYTE);
    chk("tune", clock_tune_value, TUNE_DEFAULT);
    pchk(1'b0);
  endtask
  task automatic t_selects;
    wr(CTRL_ADDR, 8'h03);
    rchk("ctrl", CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h01);
    rchk("ctrl", CTRL_ADDR, 8'h01);
    wr(CTRL_ADDR, 8'h03);
    rchk("ctrl", CTRL_ADDR, 8'h01);
    wr(CTRL_ADDR, 8'h02);
    rchk("ctrl", CTRL_ADDR, 8'h02);
    wr(CTRL_ADDR, 8'h04);
    rchk("ctrl", CTRL_ADDR, 8'h04);
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h08);
    pchk(1'b0);
    rchk("ctrl", CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h01);
    wr(CTRL_ADDR, 8'h09);
    pchk(1'b0);
    wr(CTRL_ADDR, 8'h00);
  endtask
  task automatic t_program;
    arm(8'h01, 16'hFF40);
    pchk(1'b1);
    wr(16'hFF41, 8'h5A);
    wr(16'hFF61, 8'h00);
    wr(16'hFF42, 8'h0F);
    wr(CTRL_ADDR, 8'h00);
    pchk(1'b0);
    rchk("array", 16'hFF41, 8'h5A);
    rchk("array", 16'hFF42, 8'h0F);
    rchk("array", 16'hFF61, ERASED_BYTE);
  endtask
  task automatic t_erase;
    arm(8'h02, 16'hFF7F);
    pchk(1'b1);
    wr(CTRL_ADDR, 8'h00);
    rchk("array", 16'hFF41, ERASED_BYTE);
    chk("tune", clock_tune_value, TUNE_DEFAULT);
    arm(8'h06, 16'hFF10);
    wr(CTRL_ADDR, 8'h00);
    chk("tune", clock_tune_value, ERASED_BYTE);
  endtask
  task automatic t_protect;
    arm(8'h01, 16'hFFA0);
    wr(PROTECT_ADDR, 8'hFE);
    d = 8'hFE;
    wr(CTRL_ADDR, 8'h00);
    rchk("protect", PROTECT_ADDR, 8'hFE);
    arm(8'h06, 16'hFF10);
    pchk(1'b0);
    wr(CTRL_ADDR, 8'h00);
    arm(8'h01, 16'hFF80);
    pchk(1'b0);
    wr(CTRL_ADDR, 8'h00);
    arm(8'h02, 16'hFF7F);
    pchk(1'b1);
    wr(CTRL_ADDR, 8'h00);
  endtask

  // verdict and end of run
  task automatic wrap_up;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_selects();
    t_program();
    t_erase();
    t_protect();
    wrap_up();
  end
  // watchdog
  initial begin
    #100us;
    n_mismatch++;
    wrap_up();
  end
endmodule

bind flash_program_erase_control flash_ctl_props u_props (.clk(clk), .srst(srst), .req(req),
  .rdata(rdata), .pump_on(pump_on), .array_hv(array_hv), .clock_tune_value(clock_tune_value));
